// File: include/tgpc_regs.vh
// Register offsets, field positions, reset values and sizes for the traffic generator.
`ifndef TGPC_REGS_VH
`define TGPC_REGS_VH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define TGPC_ADDR_W 8
`define TGPC_REG_CTRL 8'h00
`define TGPC_REG_LOOPS 8'h04
`define TGPC_REG_GAP 8'h08
`define TGPC_REG_STATUS 8'h0C
`define TGPC_REG_SENT 8'h10
`define TGPC_REG_RECV 8'h14
`define TGPC_REG_ELAPSED 8'h18
`define TGPC_REG_BUFLEN 8'h1C
// ****************************************************************
// Control and status fields
// ****************************************************************
`define TGPC_CTRL_START 0
`define TGPC_CTRL_STOP 1
`define TGPC_CTRL_FREE 2
`define TGPC_CTRL_CLEAR 3
`define TGPC_STAT_RUN 0
`define TGPC_STAT_DONE 1
// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define TGPC_CNT_W 16
`define TGPC_PERF_W 32
`define TGPC_BUF_AW 8
`define TGPC_ZERO16 16'h0000
`define TGPC_ONE16 16'h0001
`define TGPC_ZERO32 32'h00000000
`define TGPC_ONE32 32'h00000001
`define TGPC_ZERO8 8'h00
`define TGPC_ONE8 8'h01
`define TGPC_BUFLEN_RST 8'h01
`endif

// File: hdl/tgpc_traffic_gen.v
// Traffic generator with loop/gap control and performance counters.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "tgpc_regs.vh"

module tgpc_traffic_gen (
    input wire clk,
    input wire sys_rst,
    input wire clkEn,
    input wire [`TGPC_ADDR_W-1:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output wire [31:0] regRdData,
    output wire txValid,
    input wire txReady,
    output wire [`TGPC_BUF_AW-1:0] txIndex,
    output wire txLast,
    input wire cplDataStb,
    output wire running
);
    // ****************************************************************
    // State encoding
    // ****************************************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SEND = 3'b010;
    localparam [2:0] ST_GAP = 3'b100;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg [2:0] state_r;
    reg freeMode_r;
    reg done_r;
    reg [`TGPC_CNT_W-1:0] loopCfg_r;
    reg [`TGPC_CNT_W-1:0] gapCfg_r;
    reg [`TGPC_BUF_AW-1:0] bufLen_r;
    reg [`TGPC_BUF_AW-1:0] txIndex_r;
    reg [`TGPC_CNT_W-1:0] loopsLeft_r;
    reg [`TGPC_CNT_W-1:0] gapLeft_r;
    reg [`TGPC_PERF_W-1:0] sentCnt_r;
    reg [`TGPC_PERF_W-1:0] recvCnt_r;
    reg [`TGPC_PERF_W-1:0] elapsedCnt_r;
    reg [31:0] regRdData_r;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    wire wrCtrl = regWrStb && (regAddr == `TGPC_REG_CTRL);
    wire startCmd = wrCtrl && regWrData[`TGPC_CTRL_START];
    wire stopCmd = wrCtrl && regWrData[`TGPC_CTRL_STOP];
    wire clearCmd = wrCtrl && regWrData[`TGPC_CTRL_CLEAR];
    // The mode bit written with start governs that start, so a free run needs no loop count.
    wire freeReq = regWrData[`TGPC_CTRL_FREE];
    wire startOk = startCmd && !stopCmd && (state_r == ST_IDLE) && (freeReq || loopCfg_r != `TGPC_ZERO16);
    wire sendBeat = (state_r == ST_SEND) && txReady;
    wire lastBeat = sendBeat && (txIndex_r == bufLen_r - `TGPC_ONE8);
    // The count includes the pass in progress, so the final pass is the one that sees one.
    wire moreLoops = freeMode_r || (loopsLeft_r > `TGPC_ONE16);
    wire endRun = lastBeat && !moreLoops && !stopCmd;

    // ****************************************************************
    // Stream handshake outputs
    // ****************************************************************
    assign txValid = (state_r == ST_SEND);
    assign txLast = (state_r == ST_SEND) && (txIndex_r == bufLen_r - `TGPC_ONE8);
    assign txIndex = txIndex_r;
    assign running = (state_r != ST_IDLE);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            freeMode_r <= 1'b0;
            loopCfg_r <= `TGPC_ONE16;
            gapCfg_r <= `TGPC_ZERO16;
            bufLen_r <= `TGPC_BUFLEN_RST;
        end else if (clkEn && regWrStb) begin
            case (regAddr)
                `TGPC_REG_CTRL: begin
                    if (state_r == ST_IDLE) begin
                        freeMode_r <= regWrData[`TGPC_CTRL_FREE];
                    end
                end
                `TGPC_REG_LOOPS: loopCfg_r <= regWrData[`TGPC_CNT_W-1:0];
                `TGPC_REG_GAP: gapCfg_r <= regWrData[`TGPC_CNT_W-1:0];
                `TGPC_REG_BUFLEN: begin
                    // A zero length would put the last beat at index 255 (a 256-beat pass), so a write of zero is ignored and the length keeps its value.
                    if (regWrData[`TGPC_BUF_AW-1:0] != `TGPC_ZERO8) begin
                        bufLen_r <= regWrData[`TGPC_BUF_AW-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Replay sequencer
    // ****************************************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            txIndex_r <= `TGPC_ZERO8;
            loopsLeft_r <= `TGPC_ZERO16;
            gapLeft_r <= `TGPC_ZERO16;
        end else if (clkEn) begin
            if (stopCmd) begin
                state_r <= ST_IDLE;
                txIndex_r <= `TGPC_ZERO8;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (startOk) begin
                            state_r <= ST_SEND;
                            loopsLeft_r <= loopCfg_r;
                            txIndex_r <= `TGPC_ZERO8;
                        end
                    end
                    ST_SEND: begin
                        if (lastBeat) begin
                            txIndex_r <= `TGPC_ZERO8;
                            if (!freeMode_r) begin
                                loopsLeft_r <= loopsLeft_r - `TGPC_ONE16;
                            end
                            if (!moreLoops) begin
                                state_r <= ST_IDLE;
                            end else if (gapCfg_r != `TGPC_ZERO16) begin
                                state_r <= ST_GAP;
                                gapLeft_r <= gapCfg_r;
                            end
                        end else if (sendBeat) begin
                            txIndex_r <= txIndex_r + `TGPC_ONE8;
                        end
                    end
                    ST_GAP: begin
                        if (gapLeft_r == `TGPC_ONE16) begin
                            state_r <= ST_SEND;
                        end
                        gapLeft_r <= gapLeft_r - `TGPC_ONE16;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ****************************************************************
    // Completion flag
    // ****************************************************************
    // Set and clear never meet: a run ends only in send, a start is taken only in idle.
    always @(posedge clk) begin
        if (sys_rst) begin
            done_r <= 1'b0;
        end else if (clkEn) begin
            if (endRun) begin
                done_r <= 1'b1;
            end else if (startOk) begin
                done_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Performance counters
    // ****************************************************************
    // A new start does not clear the counters; only the clear command and reset do, so
    // a bounded run accumulates end to end and software clears between samples.
    always @(posedge clk) begin
        if (sys_rst) begin
            sentCnt_r <= `TGPC_ZERO32;
            recvCnt_r <= `TGPC_ZERO32;
            elapsedCnt_r <= `TGPC_ZERO32;
        end else if (clkEn) begin
            if (clearCmd) begin
                // An event in the clearing cycle is kept as a count of one.
                sentCnt_r <= sendBeat ? `TGPC_ONE32 : `TGPC_ZERO32;
                recvCnt_r <= cplDataStb ? `TGPC_ONE32 : `TGPC_ZERO32;
                elapsedCnt_r <= running ? `TGPC_ONE32 : `TGPC_ZERO32;
            end else begin
                if (sendBeat) begin
                    sentCnt_r <= sentCnt_r + `TGPC_ONE32;
                end
                if (cplDataStb) begin
                    recvCnt_r <= recvCnt_r + `TGPC_ONE32;
                end
                if (running) begin
                    elapsedCnt_r <= elapsedCnt_r + `TGPC_ONE32;
                end
            end
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            regRdData_r <= `TGPC_ZERO32;
        end else if (clkEn && regRdStb) begin
            case (regAddr)
                `TGPC_REG_CTRL: regRdData_r <= {29'h0, freeMode_r, 2'h0};
                `TGPC_REG_LOOPS: regRdData_r <= {16'h0, loopCfg_r};
                `TGPC_REG_GAP: regRdData_r <= {16'h0, gapCfg_r};
                `TGPC_REG_STATUS: regRdData_r <= {30'h0, done_r, running};
                `TGPC_REG_SENT: regRdData_r <= sentCnt_r;
                `TGPC_REG_RECV: regRdData_r <= recvCnt_r;
                `TGPC_REG_ELAPSED: regRdData_r <= elapsedCnt_r;
                `TGPC_REG_BUFLEN: regRdData_r <= {24'h0, bufLen_r};
                default: regRdData_r <= `TGPC_ZERO32;
            endcase
        end
    end

    assign regRdData = regRdData_r;
endmodule

// File: tb/tgpc_monitor.sv
// Concurrent checks on the traffic generator ports.
`timescale 1ns/10ps
`include "tgpc_regs.vh"
module tgpc_monitor (
    input wire clk,
    input wire sys_rst,
    input wire clkEn,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    input wire [31:0] regRdData,
    input wire txValid,
    input wire txReady,
    input wire [7:0] txIndex,
    input wire txLast,
    input wire cplDataStb,
    input wire running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire ctlWr = clkEn && regWrStb && regAddr == `TGPC_REG_CTRL;
    a_idle_no_valid: assert property (!running |-> !txValid) else $error("beat offered while idle");
    a_last_in_send: assert property (txLast |-> txValid) else $error("last flag outside send");
    a_index_step: assert property (clkEn && txValid && txReady && !regWrStb |=>
        txIndex == ($past(txLast) ? 8'h00 : $past(txIndex) + 8'h01)) else $error("index step wrong");
    a_beat_holds: assert property (clkEn && txValid && !txReady && !regWrStb |=> txValid && $stable(txIndex))
        else $error("stalled beat dropped");
    a_stop_ends: assert property (ctlWr && regWrData[`TGPC_CTRL_STOP] |=> !running && !txValid)
        else $error("stop ignored");
    a_rd_unmapped: assert property (clkEn && regRdStb && regAddr == 8'h20 |=> regRdData == 32'h00000000)
        else $error("unmapped read not zero");
    a_rd_status: assert property (clkEn && regRdStb && regAddr == `TGPC_REG_STATUS |=>
        regRdData[0] == $past(running) && regRdData[31:2] == 30'h00000000) else $error("status read wrong");
    a_freeze_hold: assert property (!clkEn |=> $stable(txIndex) && $stable(regRdData) && running == $past(running))
        else $error("state moved while disabled");
    a_reset_idle: assert property ($fell(sys_rst) |-> !running && !txValid && regRdData == 32'h00000000)
        else $error("not idle after reset");
    cover property (clkEn && txValid && txReady && txLast);
    cover property ($fell(running));
    cover property (ctlWr && regWrData[`TGPC_CTRL_FREE]);
    cover property (running && !txValid);
endmodule
bind tgpc_traffic_gen tgpc_monitor tgpc_monitor_i (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .txValid(txValid), .txReady(txReady), .txIndex(txIndex), .txLast(txLast),
    .cplDataStb(cplDataStb), .running(running));

// File: tb/tgpc_core_model.sv
// Endpoint core model: random stalls on accept, completions only while traffic flows.
`timescale 1ns/10ps
module tgpc_core_model (
    input wire clk,
    input wire txValid,
    output reg txReady = 1'b0,
    output reg cplDataStb = 1'b0
);
    integer seed = 24;
    // Gating completions on traffic keeps the counter still while software reads it.
    always @(posedge clk) begin
        txReady <= ($random(seed) % 4) != 0;
        cplDataStb <= txValid && (($random(seed) % 3) == 0);
    end
endmodule

// File: tb/tgpc_traffic_gen_tb.sv
// Self-checking bench for the traffic generator.
`timescale 1ns/10ps
`include "tgpc_regs.vh"
module tgpc_traffic_gen_tb;
    reg clk, sys_rst, clkEn, regWrStb, regRdStb;
    reg [7:0] regAddr;
    reg [31:0] regWrData, beats, cplCnt, runCyc, low, gapSeen, b, l, g;
    wire [31:0] regRdData;
    wire [7:0] txIndex;
    wire txValid, txReady, txLast, cplDataStb, running, clr;
    integer seed = 24, err_count = 0, compares = 0, cyc = 0, i, t;
    tgpc_traffic_gen tgpc_traffic_gen_i (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .txValid(txValid), .txReady(txReady), .txIndex(txIndex), .txLast(txLast),
        .cplDataStb(cplDataStb), .running(running));
    tgpc_core_model tgpc_core_model_i (.clk(clk), .txValid(txValid), .txReady(txReady), .cplDataStb(cplDataStb));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ****************************************************************
    // Reference counts, cleared in step with the counter clear.
    // ****************************************************************
    assign clr = clkEn && regWrStb && regAddr == `TGPC_REG_CTRL && regWrData[`TGPC_CTRL_CLEAR];
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            end_of_test;
        end
        if (clkEn && !sys_rst) begin
            beats = clr ? 32'h00000000 : beats + (txValid && txReady);
            cplCnt = clr ? cplDataStb : cplCnt + cplDataStb;
            runCyc = clr ? running : runCyc + running;
            if (running && !txValid) low = low + 32'h00000001;
            else if (txValid && low != 32'h00000000) begin
                gapSeen = low;
                low = 32'h00000000;
            end
        end
    end
    task chk(input [31:0] s, input [31:0] e, input string n);
        begin
            compares = compares + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    function [31:0] expSent(input [31:0] bl, input [31:0] lp);
        begin
            expSent = bl * lp;
        end
    endfunction
    function [31:0] expStatus(input done, input run);
        begin
            expStatus = {30'h00000000, done, run};
        end
    endfunction
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            regAddr <= a;
            regWrData <= d;
            regWrStb <= 1'b1;
            @(posedge clk);
            regWrStb <= 1'b0;
            // Let the reference counters take this edge before any expectation is read.
            #1;
        end
    endtask
    task rc(input [7:0] a, input [31:0] e, input string n);
        begin
            @(posedge clk);
            regAddr <= a;
            regRdStb <= 1'b1;
            @(posedge clk);
            regRdStb <= 1'b0;
            #1 chk(regRdData, e, n);
        end
    endtask
    task end_of_test;
        begin
            $display("compares %0d err_count %0d", compares, err_count);
            if (err_count == 0 && compares > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        {clkEn, sys_rst, regWrStb, regRdStb, regAddr, regWrData} = {2'b11, 42'h00000000000};
        {beats, cplCnt, runCyc, low, gapSeen} = {5{32'h00000000}};
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rc(`TGPC_REG_LOOPS, 32'h00000001, "loops");
        rc(`TGPC_REG_BUFLEN, 32'h00000001, "buflen");
        rc(8'h20, 32'h00000000, "unmapped");
        wr(`TGPC_REG_GAP, 32'h0001FFFF);
        rc(`TGPC_REG_GAP, 32'h0000FFFF, "gap max");
        wr(`TGPC_REG_LOOPS, 32'h00010000);
        wr(`TGPC_REG_CTRL, 32'h00000001);
        rc(`TGPC_REG_STATUS, expStatus(1'b0, 1'b0), "zero loops");
        for (i = 0; i < 5; i = i + 1) begin
            b = 32'h00000001 + {$random(seed)} % 4;
            l = 32'h00000002 + {$random(seed)} % 3;
            g = (i == 0) ? 32'h00000000 : {$random(seed)} % 6;
            wr(`TGPC_REG_BUFLEN, b);
            wr(`TGPC_REG_LOOPS, l);
            wr(`TGPC_REG_GAP, g);
            wr(`TGPC_REG_CTRL, 32'h00000008);
            gapSeen = 32'h00000000;
            wr(`TGPC_REG_CTRL, 32'h00000001);
            #1 for (t = 0; t < 3000 && running !== 1'b0; t = t + 1) @(posedge clk);
            rc(`TGPC_REG_STATUS, expStatus(1'b1, 1'b0), "done");
            wr(`TGPC_REG_CTRL, 32'h00000002);
            chk(beats, expSent(b, l), "beats");
            chk(gapSeen, g, "gap");
            rc(`TGPC_REG_SENT, expSent(b, l), "sent");
            rc(`TGPC_REG_RECV, cplCnt, "recv");
            rc(`TGPC_REG_ELAPSED, runCyc, "elapsed");
        end
        wr(`TGPC_REG_LOOPS, 32'h00000000);
        wr(`TGPC_REG_CTRL, 32'h00000005);
        repeat (150) @(posedge clk) clkEn <= ($random(seed) % 2) != 0;
        @(posedge clk) clkEn <= 1'b1;
        rc(`TGPC_REG_STATUS, expStatus(1'b0, 1'b1), "free run");
        wr(`TGPC_REG_CTRL, 32'h00000002);
        rc(`TGPC_REG_SENT, beats, "free sent");
        rc(`TGPC_REG_ELAPSED, runCyc, "free elapsed");
        rc(`TGPC_REG_RECV, cplCnt, "free recv");
        wr(`TGPC_REG_CTRL, 32'h00000008);
        rc(`TGPC_REG_ELAPSED, 32'h00000000, "cleared");
        wr(`TGPC_REG_CTRL, 32'h00000005);
        repeat (3) @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk) sys_rst <= 1'b0;
        rc(`TGPC_REG_STATUS, expStatus(1'b0, 1'b0), "reset");
        end_of_test;
    end
endmodule
